//--- common/gii_pkg.sv
// constants and types shared by the instrument bus interface
package gii_pkg;

  // =====================================================================
  // register map (byte addresses on the 32-bit register bus)
  localparam int GII_AW = 8;
  localparam logic [7:0] OFF_CONFIG = 8'h00;
  localparam logic [7:0] OFF_STATE = 8'h04;
  localparam logic [7:0] OFF_TXDATA = 8'h08;
  localparam logic [7:0] OFF_RXDATA = 8'h0C;
  localparam logic [7:0] OFF_EVENT = 8'h10;
  localparam logic [7:0] OFF_ERRWORD = 8'h14;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // =====================================================================
  // field positions and reset values
  localparam logic [4:0] DEF_BUS_ADDR = 5'h1B;
  localparam int TX_END_BIT = 8;
  localparam int EV_INVALID = 0;
  localparam int EV_STORED = 1;
  localparam int EV_STORE_CLR = 2;
  localparam int EV_TRIG_CLR = 4;
  localparam int EV_DCLR_CLR = 5;
  localparam int SB_RQS = 6;
  localparam int SB_ERR = 5;
  localparam int SB_READY = 4;
  localparam logic [6:0] STORE_LAST = 7'h63;

  // =====================================================================
  // interface messages, seven bits, taken while attention is true
  localparam logic [6:0] MSG_GTL = 7'h01;
  localparam logic [6:0] MSG_SDC = 7'h04;
  localparam logic [6:0] MSG_PPC = 7'h05;
  localparam logic [6:0] MSG_GET = 7'h08;
  localparam logic [6:0] MSG_TCT = 7'h09;
  localparam logic [6:0] MSG_LLO = 7'h11;
  localparam logic [6:0] MSG_DCL = 7'h14;
  localparam logic [6:0] MSG_SPE = 7'h18;
  localparam logic [6:0] MSG_SPD = 7'h19;
  localparam logic [6:0] MSG_UNL = 7'h3F;
  localparam logic [6:0] MSG_UNT = 7'h5F;
  localparam logic [1:0] GRP_LISTEN = 2'h1;
  localparam logic [1:0] GRP_TALK = 2'h2;
  localparam logic [1:0] GRP_SECOND = 2'h3;

  // =====================================================================
  // timing
  localparam int CLK_MHZ = 40;
  localparam int SETTLE_NS = 500;
  localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int SETTLE_W = 5;

  // =====================================================================
  // handshake states, gray along the usual path
  typedef enum logic [1:0] {
    A_IDLE = 2'h0,
    A_RDY = 2'h1,
    A_ACC = 2'h3,
    A_WAIT = 2'h2
  } gii_ah_e;

  typedef enum logic [1:0] {
    S_IDLE = 2'h0,
    S_SETL = 2'h1,
    S_DAV = 2'h3,
    S_DONE = 2'h2
  } gii_sh_e;

endpackage

//--- src/gii_sync.sv
// two-stage synchroniser for the bus pins, idle level is high
`timescale 1ns/1ps
`default_nettype none
module gii_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // asynchronous in, synchronised out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } gii_sync_s;

  gii_sync_s st_q;
  gii_sync_s st_d;

  always_comb begin
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end

  // reset to the released level so nothing looks asserted after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '1;
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.s2;

endmodule
`default_nettype wire

//--- src/gii_core.sv
// instrument bus device interface with register-bus control port
// Function
// R01 - status byte answers every serial poll, service request or not
// R02 - data driven only when addressed to talk or in talk-only mode
// R03 - data bytes accepted only while addressed to listen
// R04 - own listen address while talker drops the talker state
// R05 - own talk address while listener drops the listener state
// R06 - full source handshake originates each byte as talker
// R07 - full acceptor handshake latches each byte before release
// R08 - no parallel poll reply, data lines untouched in a poll
// R09 - never controller; attention, clear, remote enable only sampled
// R10 - primary address only, secondary addresses ignored
// R11 - service request line asserted on an enabled condition
// R12 - remote and local follow bus messages
// R13 - device clear reinitialises the device
// R14 - device trigger starts a reading
// R15 - status bit 6 request, bit 5 error, bit 4 reading ready
// R16 - invalid option sets error bit, illegal option flag, maybe request
// R17 - serial poll of status byte releases service request
// R18 - store of 100 readings requests service when full and enabled
// R19 - controller sends upper case strings ending with execute char
// R20 - default address 27, operator may change it
// R21 - remote only when remote enable true and then addressed to listen
// R22 - lockout disables panel until remote enable goes false
// R23 - parallel poll configure and take control ignored, no stall
// R24 - serial poll while talker sends status byte instead of data
//
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module gii_core
  import gii_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus, write side
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // register bus, read side
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // instrument bus, open-drain, low is asserted
  input wire logic [7:0] dio_n_i,
  output logic [7:0] dio_n_o,
  output logic [7:0] dio_n_oe,
  input wire logic dav_n_i,
  output logic dav_n_o,
  output logic dav_n_oe,
  input wire logic nrfd_n_i,
  output logic nrfd_n_o,
  output logic nrfd_n_oe,
  input wire logic ndac_n_i,
  output logic ndac_n_o,
  output logic ndac_n_oe,
  output logic eoi_n_o,
  output logic eoi_n_oe,
  output logic srq_n_o,
  output logic srq_n_oe,
  input wire logic atn_n_i,
  input wire logic ifc_n_i,
  input wire logic ren_n_i,
  // instrument side
  output logic dev_clear,
  output logic dev_trigger,
  output logic remote,
  output logic panel_lockout
);

  // =====================================================================
  // state
  typedef struct packed {
    gii_ah_e ah;
    gii_sh_e sh;
    logic [SETTLE_W-1:0] settle;
    logic talker;
    logic listener;
    logic remote;
    logic lockout;
    logic spms;
    logic talk_only;
    logic err_mask;
    logic full_mask;
    logic [4:0] bus_addr;
    logic err_bit;
    logic illegal_opt;
    logic ready;
    logic rqs;
    logic [6:0] store_cnt;
    logic store_full;
    logic tx_pend;
    logic [7:0] tx_byte;
    logic tx_end;
    logic rx_valid;
    logic [7:0] rx_byte;
    logic [7:0] out_byte;
    logic out_end;
    logic trig_seen;
    logic clr_seen;
    logic dev_clear;
    logic dev_trigger;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } gii_core_s;

  gii_core_s st_q;
  gii_core_s st_d;

  // =====================================================================
  // pin sampling and decode
  logic [13:0] sy;
  logic [7:0] dio_in;
  logic dav_s, nrfd_s, ndac_s, atn_s, ifc_s, ren_s;
  logic [6:0] cmd;
  logic take, cmd_take, data_take, own_la, own_ta, ah_act, talk_act;
  logic [7:0] sb, cfg_old;
  logic [31:0] wmask, wd;
  logic do_wr, ar_hs, err_ev, stored_ev, store_fill, rqs_set, poll_done;

  // attention, clear and remote enable are inputs only, never driven (see R09)
  gii_sync #(.W(14)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({ren_n_i, ifc_n_i, atn_n_i, ndac_n_i, nrfd_n_i, dav_n_i, dio_n_i}),
    .q(sy)
  );

  assign dio_in = ~sy[7:0];
  assign dav_s = ~sy[8];
  assign nrfd_s = ~sy[9];
  assign ndac_s = ~sy[10];
  assign atn_s = ~sy[11];
  assign ifc_s = ~sy[12];
  assign ren_s = ~sy[13];
  assign cmd = dio_in[6:0];

  // data bytes stall in ready-for-data until software drains the last one
  assign take = (st_q.ah == A_RDY) && dav_s && (atn_s || !st_q.rx_valid); // see R07
  assign cmd_take = take && atn_s;
  assign data_take = take && !atn_s && st_q.listener; // see R03
  assign own_la = cmd_take && cmd[6:5] == GRP_LISTEN && cmd != MSG_UNL
    && cmd[4:0] == st_q.bus_addr; // see R20
  assign own_ta = cmd_take && cmd[6:5] == GRP_TALK && cmd != MSG_UNT
    && cmd[4:0] == st_q.bus_addr;
  assign ah_act = atn_s || st_q.listener;
  assign talk_act = (st_q.talker || st_q.talk_only) && !atn_s; // see R02
  assign sb = {1'b0, st_q.rqs, st_q.err_bit, st_q.ready, 4'h0}; // see R15
  assign cfg_old = {st_q.full_mask, st_q.err_mask, st_q.talk_only, st_q.bus_addr};

  assign wmask = {{8{st_q.w_strb[3]}}, {8{st_q.w_strb[2]}},
    {8{st_q.w_strb[1]}}, {8{st_q.w_strb[0]}}};
  assign wd = st_q.w_data & wmask;
  assign do_wr = st_q.aw_got && st_q.w_got && !st_q.bvalid;
  assign ar_hs = s_axi_arvalid && !st_q.rvalid;
  assign err_ev = do_wr && st_q.aw_addr == OFF_EVENT && wd[EV_INVALID];
  assign stored_ev = do_wr && st_q.aw_addr == OFF_EVENT && wd[EV_STORED];
  assign store_fill = stored_ev && !st_q.store_full && st_q.store_cnt == STORE_LAST;
  assign rqs_set = (err_ev && st_q.err_mask) || (store_fill && st_q.full_mask);
  assign poll_done = st_q.sh == S_DAV && talk_act && !ndac_s && st_q.spms;

  // =====================================================================
  // next state
  always_comb begin
    st_d = st_q;
    st_d.dev_clear = 1'b0;
    st_d.dev_trigger = 1'b0;

    // register bus channels
    if (s_axi_awvalid && s_axi_awready) begin
      st_d.aw_got = 1'b1;
      st_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_d.w_got = 1'b1;
      st_d.w_data = s_axi_wdata;
      st_d.w_strb = s_axi_wstrb;
    end
    if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end
    if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid = 1'b0;
    end
    if (do_wr) begin
      st_d.aw_got = 1'b0;
      st_d.w_got = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp = RESP_OKAY;
      case (st_q.aw_addr)
        OFF_CONFIG: begin
          {st_d.full_mask, st_d.err_mask, st_d.talk_only, st_d.bus_addr} =
            (cfg_old & ~wmask[7:0]) | wd[7:0];
        end
        OFF_TXDATA: begin
          // a write while a byte is still pending is dropped
          if (!st_q.tx_pend && st_q.w_strb[0]) begin
            st_d.tx_pend = 1'b1;
            st_d.tx_byte = wd[7:0];
            st_d.tx_end = wd[TX_END_BIT];
          end
        end
        OFF_EVENT: begin
          if (wd[EV_TRIG_CLR]) st_d.trig_seen = 1'b0;
          if (wd[EV_DCLR_CLR]) st_d.clr_seen = 1'b0;
          if (wd[EV_STORE_CLR]) begin
            st_d.store_cnt = 7'h00;
            st_d.store_full = 1'b0;
          end
        end
        OFF_STATE, OFF_RXDATA, OFF_ERRWORD: begin
          st_d.bresp = RESP_OKAY;
        end
        default: begin
          st_d.bresp = RESP_SLVERR;
        end
      endcase
    end
    if (ar_hs) begin
      st_d.rvalid = 1'b1;
      st_d.rresp = RESP_OKAY;
      case (s_axi_araddr)
        OFF_CONFIG: st_d.rdata = {24'h000000, cfg_old};
        OFF_STATE: st_d.rdata = {8'h00, st_q.store_full, st_q.store_cnt, sb, 1'b0,
          st_q.rx_valid, st_q.tx_pend, st_q.spms, st_q.lockout, st_q.remote,
          st_q.listener, st_q.talker};
        OFF_TXDATA: st_d.rdata = {31'h00000000, st_q.tx_pend};
        OFF_RXDATA: begin
          st_d.rdata = {23'h000000, st_q.rx_valid, st_q.rx_byte};
          st_d.rx_valid = 1'b0;
        end
        OFF_EVENT: st_d.rdata = {30'h00000000, st_q.clr_seen, st_q.trig_seen};
        OFF_ERRWORD: begin
          // reading the error word acknowledges the error
          st_d.rdata = {31'h00000000, st_q.illegal_opt};
          st_d.illegal_opt = 1'b0;
          st_d.err_bit = 1'b0;
        end
        default: begin
          st_d.rdata = 32'h00000000;
          st_d.rresp = RESP_SLVERR;
        end
      endcase
    end

    // remote enable false cancels remote and lockout alike
    if (!ren_s) begin
      st_d.remote = 1'b0;
      st_d.lockout = 1'b0; // see R22
    end
    if (ifc_s) begin
      st_d.talker = 1'b0;
      st_d.listener = 1'b0;
      st_d.spms = 1'b0;
    end

    // acceptor handshake and message decode
    case (st_q.ah)
      A_IDLE: begin
        if (ah_act) st_d.ah = A_RDY;
      end
      A_RDY: begin
        if (take) begin
          st_d.ah = A_ACC; // see R07
        end else if (!ah_act) begin
          st_d.ah = A_IDLE;
        end
      end
      A_ACC: st_d.ah = A_WAIT;
      A_WAIT: begin
        if (!dav_s) st_d.ah = ah_act ? A_RDY : A_IDLE;
      end
      default: st_d.ah = A_IDLE;
    endcase
    if (data_take) begin
      st_d.rx_byte = dio_in; // see R03
      st_d.rx_valid = 1'b1;
    end
    if (cmd_take && !ifc_s) begin
      // secondary group and other listen addresses fall through untouched (see R10)
      if (cmd == MSG_UNL) st_d.listener = 1'b0;
      if (cmd == MSG_UNT) st_d.talker = 1'b0;
      if (cmd[6:5] == GRP_TALK && cmd != MSG_UNT && !own_ta) st_d.talker = 1'b0;
      if (own_la) begin
        st_d.listener = 1'b1;
        st_d.talker = 1'b0; // see R04
        if (ren_s) st_d.remote = 1'b1; // see R21
      end
      if (own_ta) begin
        st_d.talker = 1'b1;
        st_d.listener = 1'b0; // see R05
      end
      case (cmd)
        MSG_GTL: if (st_q.listener) st_d.remote = 1'b0; // see R12
        MSG_LLO: if (ren_s) st_d.lockout = 1'b1; // see R22
        MSG_SPE: st_d.spms = 1'b1;
        MSG_SPD: st_d.spms = 1'b0;
        MSG_GET: begin
          if (st_q.listener) begin
            st_d.dev_trigger = 1'b1; // see R14
            st_d.trig_seen = 1'b1;
          end
        end
        MSG_PPC, MSG_TCT: st_d.spms = st_q.spms; // see R23
        default: st_d.spms = st_d.spms;
      endcase
      if (cmd == MSG_DCL || (cmd == MSG_SDC && st_q.listener)) begin
        // panel address and talk-only survive a clear
        st_d.dev_clear = 1'b1; // see R13
        st_d.clr_seen = 1'b1;
        st_d.err_mask = 1'b0;
        st_d.full_mask = 1'b0;
        st_d.err_bit = 1'b0;
        st_d.illegal_opt = 1'b0;
        st_d.ready = 1'b0;
        st_d.rqs = 1'b0;
        st_d.store_cnt = 7'h00;
        st_d.store_full = 1'b0;
        st_d.tx_pend = 1'b0;
        st_d.rx_valid = 1'b0;
      end
    end

    // source handshake, status byte replaces data in a poll
    case (st_q.sh)
      S_IDLE: begin
        if (talk_act && (st_q.spms || st_q.tx_pend)) begin // see R01
          st_d.out_byte = st_q.spms ? sb : st_q.tx_byte; // see R24
          st_d.out_end = !st_q.spms && st_q.tx_end;
          st_d.settle = SETTLE_W'(SETTLE_CYC - 1);
          st_d.sh = S_SETL;
        end
      end
      S_SETL: begin
        if (!talk_act) begin
          st_d.sh = S_IDLE;
        end else if (st_q.settle != '0) begin
          st_d.settle = st_q.settle - 1'b1;
        end else if (!nrfd_s) begin
          st_d.sh = S_DAV; // see R06
        end
      end
      S_DAV: begin
        if (!talk_act) begin
          st_d.sh = S_IDLE;
        end else if (!ndac_s) begin
          st_d.sh = S_DONE;
          if (st_q.spms) begin
            st_d.rqs = 1'b0; // see R17
            st_d.ready = 1'b0;
          end else begin
            st_d.tx_pend = 1'b0;
          end
        end
      end
      S_DONE: st_d.sh = S_IDLE;
      default: st_d.sh = S_IDLE;
    endcase

    // event sets come last so they win over same-cycle clears
    if (err_ev) begin
      st_d.err_bit = 1'b1; // see R16
      st_d.illegal_opt = 1'b1;
    end
    if (stored_ev) begin
      st_d.ready = 1'b1;
      if (!st_q.store_full) st_d.store_cnt = st_q.store_cnt + 7'h01;
    end
    if (store_fill) st_d.store_full = 1'b1; // see R18
    if (rqs_set) st_d.rqs = 1'b1; // see R11
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
      st_q.bus_addr <= DEF_BUS_ADDR; // see R20
    end else begin
      st_q <= st_d;
    end
  end

  // =====================================================================
  // outputs
  assign s_axi_awready = !st_q.aw_got && !st_q.bvalid;
  assign s_axi_wready = !st_q.w_got && !st_q.bvalid;
  assign s_axi_bvalid = st_q.bvalid;
  assign s_axi_bresp = st_q.bresp;
  assign s_axi_arready = !st_q.rvalid;
  assign s_axi_rvalid = st_q.rvalid;
  assign s_axi_rdata = st_q.rdata;
  assign s_axi_rresp = st_q.rresp;

  // open-drain: only the enables move, the driven level is always low
  assign dio_n_o = 8'h00;
  assign dav_n_o = 1'b0;
  assign nrfd_n_o = 1'b0;
  assign ndac_n_o = 1'b0;
  assign eoi_n_o = 1'b0;
  assign srq_n_o = 1'b0;
  assign dio_n_oe = (st_q.sh != S_IDLE) ? st_q.out_byte : 8'h00; // see R08
  assign dav_n_oe = st_q.sh == S_DAV;
  assign eoi_n_oe = st_q.sh != S_IDLE && st_q.out_end;
  assign nrfd_n_oe = st_q.ah == A_ACC || st_q.ah == A_WAIT
    || (st_q.ah == A_RDY && !atn_s && st_q.rx_valid);
  assign ndac_n_oe = st_q.ah == A_RDY || st_q.ah == A_ACC;
  assign srq_n_oe = st_q.rqs; // see R11
  assign dev_clear = st_q.dev_clear;
  assign dev_trigger = st_q.dev_trigger;
  assign remote = st_q.remote;
  assign panel_lockout = st_q.lockout;

  // =====================================================================
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence poll_byte_s;
    st_q.spms && talk_act && st_q.sh == S_IDLE;
  endsequence
  sequence store_full_s;
    store_fill && st_q.full_mask;
  endsequence

  talk_gate_a: assert property ( // see R02
    dio_n_oe != 8'h00 |-> st_q.talker || st_q.talk_only)
    else $error("data driven while not talker");
  poll_quiet_a: assert property ( // see R08
    atn_s [*2] |-> dio_n_oe == 8'h00)
    else $error("data lines driven under attention");
  listen_only_a: assert property ( // see R03
    $rose(st_q.rx_valid) |-> $past(st_q.listener) && !$past(atn_s))
    else $error("data byte taken while not listener");
  drop_talker_a: assert property ( // see R04
    own_la && !ifc_s |=> !st_q.talker && st_q.listener)
    else $error("talker kept after own listen address");
  drop_listener_a: assert property ( // see R05
    own_ta && !ifc_s |=> st_q.talker && !st_q.listener)
    else $error("listener kept after own talk address");
  settle_first_a: assert property ( // see R06
    $rose(dav_n_oe) |-> $past(st_q.sh, SETTLE_CYC) == S_SETL)
    else $error("data valid before settling time");
  latch_hold_a: assert property ( // see R07
    take |=> nrfd_n_oe && ndac_n_oe ##1 nrfd_n_oe && !ndac_n_oe)
    else $error("acceptor released before latch");
  secondary_ignored_a: assert property ( // see R10
    cmd_take && cmd[6:5] == GRP_SECOND && !ifc_s |=> $stable(st_q.talker)
      && $stable(st_q.listener))
    else $error("secondary address changed addressing");
  status_byte_a: assert property ( // see R15
    poll_byte_s |=> st_q.out_byte == {1'b0, $past(st_q.rqs), $past(st_q.err_bit),
      $past(st_q.ready), 4'h0})
    else $error("wrong status byte offered in poll");
  error_request_a: assert property ( // see R16
    err_ev && st_q.err_mask |=> srq_n_oe && st_q.err_bit && st_q.illegal_opt)
    else $error("invalid option not flagged");
  poll_release_a: assert property ( // see R17
    poll_done && !rqs_set |=> !srq_n_oe)
    else $error("service request kept after poll");
  store_request_a: assert property ( // see R18
    store_full_s |=> srq_n_oe && st_q.store_full && st_q.store_cnt == 7'h64)
    else $error("store full did not request service");
  remote_entry_a: assert property ( // see R21
    $rose(st_q.remote) |-> $past(own_la) && $past(ren_s))
    else $error("remote entered without listen address");
  lockout_hold_a: assert property ( // see R22
    st_q.lockout && ren_s |=> st_q.lockout)
    else $error("lockout lost while remote enable true");
  clear_pulse_a: assert property ( // see R13
    cmd_take && !ifc_s && cmd == MSG_DCL |=> dev_clear && !st_q.rqs ##1 !dev_clear)
    else $error("device clear not applied");

endmodule
`default_nettype wire

//--- testbench/gii_ctrl_model.sv
// bus controller model for the instrument bus, pulls a line low to assert it
`timescale 1ns/1ps
`default_nettype none
module gii_ctrl_model (
  // clock
  input wire logic aclk,
  // resolved bus levels, low is asserted
  input wire logic [7:0] dio_n,
  input wire logic dav_n,
  input wire logic nrfd_n,
  input wire logic ndac_n,
  // controller pulls and control lines
  output logic [7:0] dio_pull,
  output logic dav_pull,
  output logic nrfd_pull,
  output logic ndac_pull,
  output logic atn_n,
  output logic ren_n,
  output logic ifc_n
);
  initial begin
    {dio_pull, dav_pull, nrfd_pull, ndac_pull} = '0;
    {atn_n, ren_n, ifc_n} = 3'h7;
  end

  // ==========================================================
  // source side, atn picks command or data
  task automatic send(input logic atn, input logic [7:0] b);
    @(posedge aclk);
    {nrfd_pull, ndac_pull} <= 2'h0;
    atn_n <= !atn;
    dio_pull <= b;
    // give the synchronised acceptor time to settle into ready
    repeat (6) @(posedge aclk);
    do @(negedge aclk); while (!nrfd_n);
    @(posedge aclk);
    dav_pull <= 1'b1;
    do @(negedge aclk); while (!ndac_n);
    @(posedge aclk);
    dav_pull <= 1'b0;
    dio_pull <= 8'h00;
  endtask

  // ==========================================================
  // acceptor side, not ready again once the byte is taken
  task automatic recv(output logic [7:0] b);
    @(posedge aclk);
    atn_n <= 1'b1;
    {nrfd_pull, ndac_pull} <= 2'h1;
    do @(negedge aclk); while (dav_n);
    b = ~dio_n;
    @(posedge aclk);
    {nrfd_pull, ndac_pull} <= 2'h2;
    do @(negedge aclk); while (!dav_n);
    @(posedge aclk);
    {nrfd_pull, ndac_pull} <= 2'h3;
  endtask

  task automatic set_ren(input logic v);
    @(posedge aclk);
    ren_n <= !v;
  endtask
endmodule
`default_nettype wire

//--- testbench/test_gpib_instrument_interface.sv
// self-checking bench for the instrument bus device interface
`timescale 1ns/1ps
`default_nettype none
module test_gpib_instrument_interface
  import gii_pkg::*;
;
  logic aclk, aresetn, aw_v, aw_r, w_v, w_r, b_v, b_r, ar_v, ar_r, r_v, r_r;
  logic [7:0] aw_a, ar_a, dio_oe, dio_pull, dio_n, b;
  logic [31:0] w_d, r_d, got;
  logic [3:0] strb;
  logic [1:0] b_s, r_s, gresp;
  logic dav_oe, nrfd_oe, ndac_oe, srq_oe, dav_pull, nrfd_pull, ndac_pull;
  logic atn_n, ifc_n, ren_n, dclr, dtrig, remote, lockout, eoi_oe, eoi_dav;
  int n_trig = 0;
  int n_clr = 0;
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;
  assign dio_n = ~(dio_oe | dio_pull);

  gii_core gii_core_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw_a),
    .s_axi_awvalid(aw_v), .s_axi_awready(aw_r), .s_axi_wdata(w_d), .s_axi_wstrb(strb),
    .s_axi_wvalid(w_v), .s_axi_wready(w_r), .s_axi_bresp(b_s), .s_axi_bvalid(b_v),
    .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r),
    .s_axi_rdata(r_d), .s_axi_rresp(r_s), .s_axi_rvalid(r_v), .s_axi_rready(r_r),
    .dio_n_i(dio_n), .dio_n_o(), .dio_n_oe(dio_oe), .dav_n_i(!(dav_oe | dav_pull)),
    .dav_n_o(), .dav_n_oe(dav_oe), .nrfd_n_i(!(nrfd_oe | nrfd_pull)), .nrfd_n_o(),
    .nrfd_n_oe(nrfd_oe), .ndac_n_i(!(ndac_oe | ndac_pull)), .ndac_n_o(),
    .ndac_n_oe(ndac_oe), .eoi_n_o(), .eoi_n_oe(eoi_oe), .srq_n_o(), .srq_n_oe(srq_oe),
    .atn_n_i(atn_n), .ifc_n_i(ifc_n), .ren_n_i(ren_n), .dev_clear(dclr),
    .dev_trigger(dtrig), .remote(remote), .panel_lockout(lockout));

  gii_ctrl_model gii_ctrl_model_inst (.aclk(aclk), .dio_n(dio_n),
    .dav_n(!(dav_oe | dav_pull)), .nrfd_n(!(nrfd_oe | nrfd_pull)),
    .ndac_n(!(ndac_oe | ndac_pull)), .dio_pull(dio_pull), .dav_pull(dav_pull),
    .nrfd_pull(nrfd_pull), .ndac_pull(ndac_pull), .atn_n(atn_n), .ren_n(ren_n),
    .ifc_n(ifc_n));

  initial aclk = 1'b0;
  always #12.5 aclk = ~aclk;

  // end flag as it stood with data valid, and pulse counts
  always @(posedge aclk) begin
    if (dav_oe) eoi_dav <= eoi_oe;
    n_trig <= n_trig + dtrig;
    n_clr <= n_clr + dclr;
  end

  // ==========================================================
  // checking and register bus tasks
  task automatic chk(input string nm, input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // ready is sampled mid-cycle, it only moves on the rising edge
  task automatic hold(ref logic s);
    logic r;
    do begin
      @(negedge aclk);
      r = s;
      @(posedge aclk);
    end while (r !== 1'b1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    aw_a <= a;
    w_d <= d;
    {aw_v, w_v, b_r} <= 3'h7;
    fork
      begin hold(aw_r); aw_v <= 1'b0; end
      begin hold(w_r); w_v <= 1'b0; end
    join
    hold(b_v);
    b_r <= 1'b0;
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m, e);
    @(posedge aclk);
    ar_a <= a;
    {ar_v, r_r} <= 2'h3;
    hold(ar_r);
    ar_v <= 1'b0;
    do begin
      @(negedge aclk);
      {got, gresp} = {r_d, r_s};
      @(posedge aclk);
    end while (r_v !== 1'b1);
    r_r <= 1'b0;
    chk(nm, got & m, e);
  endtask

  task automatic cmd(input logic [6:0] c);
    gii_ctrl_model_inst.send(1'b1, {1'b0, c});
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // the whole run needs about a thousand cycles, this leaves ample margin
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      tally_and_finish;
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    {aresetn, aw_v, w_v, b_r, ar_v, r_r, aw_a, ar_a, w_d} = '0;
    strb = 4'hF;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rchk("address", OFF_CONFIG, 32'h1F, 32'h1B);
    rchk("unmapped", 8'h40, 32'hFFFFFFFF, 32'h0);
    chk("unmapped resp", gresp, RESP_SLVERR);
    gii_ctrl_model_inst.set_ren(1'b1);
    repeat (6) @(posedge aclk);
    chk("remote early", remote, 1'b0);
    cmd(7'h3B);
    rchk("listener", OFF_STATE, 32'h7, 32'h6);
    gii_ctrl_model_inst.send(1'b0, 8'h58);
    rchk("rx byte", OFF_RXDATA, 32'h1FF, 32'h158);
    cmd(MSG_GET);
    rchk("trigger", OFF_EVENT, 32'h1, 32'h1);
    cmd(MSG_PPC);
    cmd(MSG_TCT);
    cmd(MSG_LLO);
    chk("lockout", lockout, 1'b1);
    cmd(MSG_GTL);
    chk("local", {remote, lockout}, 2'h1);
    gii_ctrl_model_inst.set_ren(1'b0);
    repeat (6) @(posedge aclk);
    chk("unlock", lockout, 1'b0);
    cmd(7'h5B);
    cmd(7'h7B);
    rchk("talker", OFF_STATE, 32'h3, 32'h1);
    wr(OFF_TXDATA, 32'h1A5);
    gii_ctrl_model_inst.recv(b);
    chk("talked", b, 8'hA5);
    chk("eoi", eoi_dav, 1'b1);
    wr(OFF_CONFIG, 32'h5B);
    wr(OFF_EVENT, 32'h1);
    repeat (3) @(posedge aclk);
    chk("srq on error", srq_oe, 1'b1);
    rchk("status", OFF_STATE, 32'hFF00, 32'h6000);
    cmd(MSG_SPE);
    cmd(7'h5B);
    gii_ctrl_model_inst.recv(b);
    chk("polled", b, 8'h60);
    gii_ctrl_model_inst.recv(b);
    chk("repoll", b, 8'h20);
    chk("no eoi", eoi_dav, 1'b0);
    repeat (4) @(posedge aclk);
    chk("srq cleared", srq_oe, 1'b0);
    cmd(MSG_SPD);
    rchk("illegal", OFF_ERRWORD, 32'h1, 32'h1);
    cmd(7'h3B);
    rchk("talk dropped", OFF_STATE, 32'h3, 32'h2);
    wr(OFF_CONFIG, 32'h3B);
    wr(OFF_TXDATA, 32'h43);
    gii_ctrl_model_inst.recv(b);
    chk("talk only", b, 8'h43);
    wr(OFF_CONFIG, 32'h9B);
    for (int i = 0; i < 100; i++) begin
      chk("srq store", srq_oe, 1'b0);
      wr(OFF_EVENT, 32'h2);
    end
    repeat (3) @(posedge aclk);
    chk("srq full", srq_oe, 1'b1);
    rchk("store full", OFF_STATE, 32'hFF0000, 32'hE40000);
    cmd(MSG_DCL);
    rchk("cleared", OFF_EVENT, 32'h2, 32'h2);
    rchk("store reset", OFF_STATE, 32'hFF0000, 32'h0);
    chk("trigger pulses", n_trig, 1);
    chk("clear pulses", n_clr, 1);
    tally_and_finish;
  end
endmodule
`default_nettype wire
